// ===== swpm_pkg.sv
// Purpose: constants and types for the switch detector power mode fsm
// Assumes: 40 MHz core clock, 22 input channels
// Notes:   timing counts derived from times in their own units
package swpm_pkg;
  localparam int          CLK_MHZ        = 40;
  localparam int          NCH            = 22;
  localparam int          FUSE_US        = 50;
  localparam int          FUSE_CYC       = FUSE_US * CLK_MHZ;
  localparam int          POLL_ACT_US    = 10;
  localparam int          POLL_ACT_CYC   = POLL_ACT_US * CLK_MHZ;
  localparam int          TMR_W          = 24;
  localparam logic [21:0] CH_ZERO        = 22'h000000;
  localparam logic [23:0] TMR_ZERO       = 24'h000000;
  localparam logic [1:0]  WIRING_DEFAULT = 2'h0;

  typedef enum logic [2:0]
  {
    ST_RESET = 3'b000,
    ST_UVLO  = 3'b001,
    ST_FUSE  = 3'b010,
    ST_NORM  = 3'b011,
    ST_LPM   = 3'b100,
    ST_POLL  = 3'b101
  } swpm_state_t;

  // low power command settings, captured together
  typedef struct packed
  {
    logic [23:0] int_timer;
    logic [23:0] poll_timer;
  } swpm_lpm_cfg_t;

  // fault detector inputs
  typedef struct packed
  {
    logic overvolt;
    logic overtemp;
    logic therm_warn;
    logic spi_err;
    logic hash_err;
  } swpm_faults_t;
endpackage : swpm_pkg

// ===== swpm_fsm.sv
// Purpose: operating mode state machine of the switch detector
// Assumes: analog pins arrive asynchronous and are synchronised here
// Notes:   serial framing lives elsewhere; this block gates it
// Function
// - undervoltage holds registers, blocks serial, analog off
// - slow oscillator enabled from undervoltage onward, fast one off in low power
// - fuse read about 50 us then normal
// - wake pin low in normal, released otherwise
// - normal mode latches all five fault kinds
// - only enter-low-power command enters low power
// - low power: fast clock off, faults ignored
// - poll inputs, compare with captured entry state
// - undervoltage pauses polling without waking
// - poll ends in low power or normal
// - comparator-only inputs wake continuously
// - no wake enables: no input wake, poll timer stopped
// - registers preserved through low power
// - listed wake sources move to normal
// - pin wakes need io supply high
// - interrupt timer expiry raises interrupt, wakes
// - interrupt timer beats coincident poll
// - open-and-still-open inputs dropped from poll
// - threshold polarity depends on switch wiring
// - thermal limits merged, current cut, warning
// - power-on reset defaults registers, sets flag
`timescale 1ns/1ps
module swpm_fsm
  import swpm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // supplies and analog status, asynchronous
  input  wire logic              battery_supply_ok,
  input  wire logic              io_supply_ok,
  input  wire logic [NCH-1:0]    comp_above,
  input  wire logic [7:0]        thermal_limit_cells,
  input  wire logic              therm_warn_in,
  input  wire swpm_faults_t      fault_in,
  // pins, asynchronous
  input  wire logic              wake_pin_in,
  input  wire logic              int_pin_in,
  input  wire logic              cs_pin_in,
  // configuration from the register file
  input  wire logic [NCH-1:0]    battery_switch_config,
  input  wire logic [NCH-1:0]    wake_en,
  input  wire logic [NCH-1:0]    comp_only,
  input  wire logic              wake_pin_wake_en,
  // enter low power command, one cycle pulse from serial logic
  input  wire logic              lpm_cmd,
  input  wire swpm_lpm_cfg_t     lpm_cfg,
  input  wire logic              fault_clear,
  // outputs
  output logic                   wake_pin_oe,
  output logic                   wake_pin_out,
  output logic                   int_req,
  output logic                   spi_enable,
  output logic                   miso_enable,
  output logic                   reg_write_en,
  output logic                   analog_selector_en,
  output logic                   isrc_en,
  output logic [NCH-1:0]         isrc_ch_en,
  output logic                   isrc_min,
  output logic                   osc_fast_en,
  output logic                   osc_slow_en,
  output logic                   por_flag,
  output logic                   wake_reported,
  output swpm_faults_t           fault_latched,
  output logic                   thermal_limit,
  output logic [NCH-1:0]         sw_closed,
  output swpm_state_t            state
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  localparam int SW = NCH + 8 + 1 + 5 + 5;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  always_ff @(posedge clk)
  begin
    s1_reg <= {comp_above, thermal_limit_cells, therm_warn_in, fault_in,
               battery_supply_ok, io_supply_ok, wake_pin_in, int_pin_in,
               cs_pin_in};
    s2_reg <= s1_reg;
  end

  logic [NCH-1:0] comp_s;
  logic [7:0]     thermal_limit_s;
  swpm_faults_t   flt_s;
  logic           twarn_s, bat_s, io_s, wake_s, int_s, cs_s;
  assign {comp_s, thermal_limit_s, twarn_s, flt_s, bat_s, io_s, wake_s, int_s,
          cs_s} = s2_reg;

  // pin edge detection on synchronised copies
  logic wake_d_reg, int_d_reg, cs_d_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wake_d_reg <= 1'b1;
      int_d_reg  <= 1'b1;
      cs_d_reg   <= 1'b1;
    end
    else
    begin
      wake_d_reg <= wake_s;
      int_d_reg  <= int_s;
      cs_d_reg   <= cs_s;
    end
  end
  logic wake_fall, int_fall, cs_fall;
  assign wake_fall = wake_d_reg & ~wake_s & wake_pin_wake_en;
  assign int_fall  = int_d_reg & ~int_s;
  assign cs_fall   = cs_d_reg & ~cs_s;

  ////////////////////////////////////////////////////////////////////////
  // switch interpretation
  // above threshold is open for ground, closed for battery wiring
  assign sw_closed = comp_s ~^ battery_switch_config;

  ////////////////////////////////////////////////////////////////////////
  // state machine and timers
  swpm_state_t      state_reg, state_next;
  logic [TMR_W-1:0] fuse_cnt_reg, int_cnt_reg, poll_cnt_reg, act_cnt_reg;
  logic [NCH-1:0]   snap_reg, poll_mask_reg;
  swpm_lpm_cfg_t    cfg_reg;

  logic any_wake_en, pin_wake, int_expire, poll_due;
  logic poll_chg, comp_chg, fuse_done, act_done;
  assign any_wake_en = |wake_en;
  assign pin_wake    = (wake_fall | int_fall | cs_fall) & io_s;
  assign int_expire  = (cfg_reg.int_timer != TMR_ZERO) &&
                       (int_cnt_reg == cfg_reg.int_timer);
  assign poll_due    = any_wake_en && (cfg_reg.poll_timer != TMR_ZERO) &&
                       (poll_cnt_reg == cfg_reg.poll_timer);
  // only enabled, still polled channels count
  assign poll_chg    = |((sw_closed ^ snap_reg) & wake_en & ~comp_only
                         & poll_mask_reg);
  assign comp_chg    = |((sw_closed ^ snap_reg) & wake_en & comp_only);
  assign fuse_done   = (fuse_cnt_reg == TMR_W'(FUSE_CYC - 1));
  assign act_done    = (act_cnt_reg == TMR_W'(POLL_ACT_CYC - 1));

  // next state selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = ST_UVLO;
      ST_UVLO:  if (bat_s) state_next = ST_FUSE;
      ST_FUSE:  if (fuse_done) state_next = ST_NORM;
      ST_NORM:
      begin
        if (!bat_s) state_next = ST_UVLO;
        else if (lpm_cmd) state_next = ST_LPM;
      end
      ST_LPM:
      begin
        if (int_expire || pin_wake || comp_chg) state_next = ST_NORM;
        else if (poll_due && bat_s) state_next = ST_POLL;
      end
      ST_POLL:
      begin
        if (int_expire || pin_wake || comp_chg || poll_chg)
          state_next = ST_NORM;
        else if (act_done || !bat_s) state_next = ST_LPM;
      end
      default:  state_next = ST_RESET;
    endcase
  end

  // state register; power-on reset is the synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end
  assign state = state_reg;

  // fuse read timer
  always_ff @(posedge clk)
  begin
    if (rst || state_reg != ST_FUSE)
      fuse_cnt_reg <= TMR_ZERO;
    else
      fuse_cnt_reg <= fuse_cnt_reg + 1'b1;
  end

  // capture settings and input snapshot on going from normal to low power
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_reg  <= '0;
      snap_reg <= CH_ZERO;
    end
    else if (state_reg == ST_NORM && state_next == ST_LPM)
    begin
      cfg_reg  <= lpm_cfg;
      snap_reg <= sw_closed;
    end
  end

  // interrupt timer runs in low power and poll, polling timer in low power only
  always_ff @(posedge clk)
  begin
    if (rst || (state_reg != ST_LPM && state_reg != ST_POLL))
    begin
      int_cnt_reg  <= TMR_ZERO;
      poll_cnt_reg <= TMR_ZERO;
    end
    else
    begin
      int_cnt_reg <= int_cnt_reg + 1'b1;
      if (!any_wake_en || state_reg == ST_POLL)
        poll_cnt_reg <= TMR_ZERO;
      else if (bat_s)
        poll_cnt_reg <= poll_cnt_reg + 1'b1;
    end
  end

  // poll window counter and per channel exclusion mask
  always_ff @(posedge clk)
  begin
    if (rst || state_reg != ST_POLL)
    begin
      act_cnt_reg   <= TMR_ZERO;
      poll_mask_reg <= {NCH{1'b1}};
    end
    else
    begin
      act_cnt_reg   <= act_cnt_reg + 1'b1;
      poll_mask_reg <= poll_mask_reg & ~(~snap_reg & ~sw_closed);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault latching, normal mode only; set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_latched <= '0;
    else if (state_reg == ST_NORM)
      fault_latched <= (fault_clear ? '0 : fault_latched)
                     | flt_s | {1'b0, thermal_limit, twarn_s, 2'b00};
  end

  // merged thermal limit; cells hold until cooled past hysteresis
  always_ff @(posedge clk)
  begin
    if (rst)
      thermal_limit <= 1'b0;
    else
      thermal_limit <= (state_reg == ST_NORM) && (|thermal_limit_s);
  end
  assign isrc_min = thermal_limit;

  // power on flag and wake report
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      por_flag      <= 1'b1;
      wake_reported <= 1'b0;
      int_req       <= 1'b0;
    end
    else
    begin
      if (fault_clear) por_flag <= 1'b0;
      if ((state_reg == ST_LPM || state_reg == ST_POLL) &&
          state_next == ST_NORM)
      begin
        wake_reported <= 1'b1;
        int_req       <= 1'b1;
      end
      else if (fault_clear)
      begin
        wake_reported <= 1'b0;
        int_req       <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode dependent outputs
  logic norm;
  assign norm               = (state_reg == ST_NORM);
  assign spi_enable         = norm;
  assign miso_enable        = norm && !cs_s;
  assign reg_write_en       = norm;
  assign analog_selector_en = norm;
  assign isrc_en            = norm || (state_reg == ST_POLL);
  assign isrc_ch_en         = norm ? {NCH{1'b1}} :
                              (state_reg == ST_POLL) ? poll_mask_reg :
                              CH_ZERO;
  assign osc_fast_en        = (state_reg != ST_LPM);
  assign osc_slow_en        = (state_reg != ST_RESET);
  assign wake_pin_oe        = norm;
  assign wake_pin_out       = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_fuse_len: assert property (@(posedge clk) disable iff (rst)
    $rose(state_reg == ST_FUSE) |-> (state_reg == ST_FUSE) [*8])
    else $error("fuse read too short");
  chk_lpm_entry: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_NORM) ##1 (state_reg == ST_LPM) |-> $past(lpm_cmd))
    else $error("low power entered without command");
  chk_wake_pin: assert property (@(posedge clk) disable iff (rst)
    wake_pin_oe == (state_reg == ST_NORM))
    else $error("wake pin drive wrong");
  chk_uv_spi: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_UVLO) |-> !spi_enable && !isrc_en && !miso_enable)
    else $error("undervoltage not locked out");
  chk_fast_osc: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_LPM) |-> !osc_fast_en)
    else $error("fast oscillator on in low power");
  chk_fault_hold: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_LPM) ##1 (state_reg == ST_LPM) |->
      $stable(fault_latched))
    else $error("fault latched in low power");
  chk_int_wake: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_LPM && int_expire) |=> state_reg == ST_NORM && int_req)
    else $error("interrupt timer did not wake");
  chk_poll_stop: assert property (@(posedge clk) disable iff (rst)
    (!any_wake_en && state_reg == ST_LPM) |=> state_reg != ST_POLL)
    else $error("poll with no wake enables");
  chk_reset_hold: assert property (@(posedge clk)
    rst |=> state_reg == ST_RESET)
    else $error("reset did not hold fsm");
endmodule // swpm_fsm

// ===== swpm_host.sv
// Purpose: host model driving the command and the pin pulls
// Assumes: pins idle high through pull-ups
// Notes:   changes only just after a rising edge
`timescale 1ns/1ps
module swpm_host
  import swpm_pkg::*;
(
  // clock
  input  wire logic     clk,
  // command to the fsm
  output swpm_lpm_cfg_t lpm_cfg,
  output logic          lpm_cmd,
  // pin pull-downs
  output logic          cs_low,
  output logic          int_low,
  output logic          wake_low
);
  // idle levels
  initial
  begin
    lpm_cfg  = '0;
    lpm_cmd  = 1'h0;
    cs_low   = 1'h0;
    int_low  = 1'h0;
    wake_low = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // settings travel with the one command word
  task automatic enter_lpm(input logic [23:0] it, input logic [23:0] pt);
    @(posedge clk);
    lpm_cfg <= '{it, pt};
    lpm_cmd <= 1'h1;
    @(posedge clk);
    lpm_cmd <= 1'h0;
  endtask

  // one pin low for six cycles; replies after a select wake are unused
  task automatic pin_pulse(input int sel);
    @(posedge clk);
    cs_low   <= (sel == 0);
    int_low  <= (sel == 1);
    wake_low <= (sel == 2);
    repeat (6) @(posedge clk);
    cs_low   <= 1'h0;
    int_low  <= 1'h0;
    wake_low <= 1'h0;
  endtask
endmodule // swpm_host

// ===== switch_detector_power_mode_fsm_bench.sv
// Purpose: self-checking bench for the power mode fsm
// Assumes: host model drives command and pin pulls
// Notes:   driver queues notes, monitor compares at falling edge
`timescale 1ns/1ps
module switch_detector_power_mode_fsm_bench
  import swpm_pkg::*;
;
  typedef struct packed
  {
    logic [3:0]  sel;
    logic [31:0] val;
  } swpm_note_t;

  logic           clk, rst, battery_supply_ok, io_supply_ok, therm_warn_in;
  logic           wake_pin_wake_en, fault_clear, lpm_cmd, cs_low, int_low;
  logic           wake_low, wake_pin_oe, wake_pin_out, int_req, spi_enable;
  logic           reg_write_en, analog_selector_en, isrc_en, isrc_min;
  logic           osc_fast_en, osc_slow_en, por_flag, wake_reported;
  logic           thermal_limit, miso_enable;
  logic [NCH-1:0] comp_above, battery_switch_config, wake_en, comp_only;
  logic [NCH-1:0] sw_closed, isrc_ch_en;
  logic [7:0]     thermal_limit_cells;
  logic [31:0]    r;
  swpm_faults_t   fault_in, fault_latched;
  swpm_lpm_cfg_t  lpm_cfg;
  swpm_state_t    state;
  swpm_note_t     exp_q[$];
  swpm_note_t     nt;
  int             err_total, samples_checked, cycles, seed, k;
  // pins resolved from every party's pull-down
  wire logic      cs_pin   = ~cs_low;
  wire logic      int_pin  = ~(int_low | int_req);
  wire logic      wake_pin = ~(wake_low | (wake_pin_oe & ~wake_pin_out));

  swpm_fsm dut (.clk, .rst, .battery_supply_ok, .io_supply_ok, .comp_above,
    .thermal_limit_cells, .therm_warn_in, .fault_in, .wake_pin_in(wake_pin),
    .int_pin_in(int_pin), .cs_pin_in(cs_pin), .battery_switch_config,
    .wake_en, .comp_only, .wake_pin_wake_en, .lpm_cmd, .lpm_cfg, .fault_clear,
    .wake_pin_oe, .wake_pin_out, .int_req, .spi_enable, .miso_enable,
    .reg_write_en, .analog_selector_en, .isrc_en, .isrc_ch_en, .isrc_min,
    .osc_fast_en, .osc_slow_en, .por_flag, .wake_reported, .fault_latched,
    .thermal_limit, .sw_closed, .state);
  swpm_host host (.clk, .lpm_cfg, .lpm_cmd, .cs_low, .int_low, .wake_low);
  //////////////////////////////////////////////////////////////////////////
  // clock
  always #12.5 clk = ~clk;

  // output picked by a note
  function automatic logic [31:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {29'h0, state};
      4'h1: seen = {31'h0, wake_pin_oe};
      4'h2: seen = {30'h0, osc_fast_en, osc_slow_en};
      4'h3: seen = {31'h0, int_req};
      4'h4: seen = {27'h0, fault_latched};
      4'h5: seen = {10'h0, sw_closed};
      4'h6: seen = {30'h0, thermal_limit, isrc_min};
      4'h7: seen = {28'h0, spi_enable, analog_selector_en, isrc_en,
                    reg_write_en};
      4'h9: seen = {31'h0, wake_reported};
      4'hA: seen = {9'h0, miso_enable, isrc_ch_en};
      default: seen = {31'h0, por_flag};
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [3:0] s, input logic [31:0] v);
    exp_q.push_back('{s, v});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic clear_flags();
    @(posedge clk);
    fault_clear <= 1'h1;
    @(posedge clk);
    fault_clear <= 1'h0;
    cyc(2);
  endtask

  task automatic done(input string nm);
    cyc(1);
    $display("test %s finished", nm);
  endtask

  task automatic complete_run();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // monitor: all queued notes, oldest first, against the outputs
  always @(negedge clk)
  begin
    while (exp_q.size() != 0)
    begin
      nt = exp_q.pop_front();
      check(seen(nt.sel), nt.val);
    end
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  // main sequence
  initial
  begin
    seed = 32'hE4573137;
    {err_total, samples_checked, cycles} = '0;
    {clk, rst, fault_clear, battery_supply_ok} = 4'h4;
    {io_supply_ok, therm_warn_in, wake_pin_wake_en} = 3'h4;
    {wake_en, comp_only, fault_in, thermal_limit_cells} = '0;
    comp_above = NCH'($random(seed));
    battery_switch_config = NCH'($random(seed));
    cyc(3);
    note(4'h0, ST_RESET);
    note(4'h8, 32'h1);
    rst <= 1'h0;
    cyc(3);
    host.enter_lpm(24'h0, 24'h0);
    note(4'h0, ST_UVLO);
    note(4'h7, 32'h0);
    note(4'h2, 32'h3);
    note(4'h5, {10'h0, comp_above ^ ~battery_switch_config});
    note(4'hA, 32'h0);
    battery_supply_ok <= 1'h1;
    cyc(100);
    note(4'h0, ST_FUSE);
    cyc(FUSE_CYC - 120);
    note(4'h0, ST_FUSE);
    cyc(40);
    note(4'h0, ST_NORM);
    note(4'h1, 32'h1);
    note(4'h7, 32'hF);
    note(4'hA, 32'h3FFFFF);
    r = $random(seed);
    fault_in <= r[4:0] | 5'h01;
    cyc(6);
    fault_in <= 5'h00;
    cyc(6);
    note(4'h4, {27'h0, r[4:0] | 5'h01});
    clear_flags();
    thermal_limit_cells <= 8'h20;
    therm_warn_in <= 1'h1;
    cyc(6);
    note(4'h6, 32'h3);
    thermal_limit_cells <= 8'h00;
    therm_warn_in <= 1'h0;
    cyc(6);
    note(4'h6, 32'h0);
    note(4'h4, 32'hC);
    done("power up and faults");
    clear_flags();
    host.enter_lpm(24'h0, 24'h32);
    note(4'h0, ST_LPM);
    note(4'h1, 32'h0);
    note(4'h2, 32'h1);
    note(4'h7, 32'h0);
    note(4'hA, 32'h0);
    fault_in <= 5'h1F;
    comp_above <= ~comp_above;
    cyc(300);
    note(4'h0, ST_LPM);
    io_supply_ok <= 1'h0;
    cyc(4);
    host.pin_pulse(0);
    note(4'h0, ST_LPM);
    io_supply_ok <= 1'h1;
    fault_in <= 5'h00;
    cyc(4);
    host.pin_pulse(0);
    note(4'h0, ST_NORM);
    note(4'h9, 32'h1);
    note(4'h4, 32'h0);
    note(4'hA, 32'h7FFFFF);
    for (k = 1; k < 3; k++)
    begin
      clear_flags();
      wake_pin_wake_en <= 1'h1;
      host.enter_lpm(24'h0, 24'h0);
      cyc(4);
      host.pin_pulse(k);
      note(4'h0, ST_NORM);
    end
    done("pin wakes");
    clear_flags();
    wake_en <= '1;
    host.enter_lpm(24'h64, 24'h64);
    cyc(94);
    note(4'h0, ST_LPM);
    cyc(10);
    note(4'h0, ST_NORM);
    note(4'h3, 32'h1);
    clear_flags();
    host.enter_lpm(24'h0, 24'h28);
    battery_supply_ok <= 1'h0;
    cyc(100);
    note(4'h0, ST_LPM);
    battery_supply_ok <= 1'h1;
    cyc(20);
    note(4'h0, ST_LPM);
    cyc(40);
    note(4'h0, ST_POLL);
    note(4'hA, {10'h0, comp_above ^ ~battery_switch_config});
    comp_above <= comp_above ^ 22'h000008;
    cyc(1000);
    note(4'h0, ST_NORM);
    clear_flags();
    comp_only <= 22'h000020;
    host.enter_lpm(24'h0, 24'h0);
    cyc(10);
    comp_above <= comp_above ^ 22'h000020;
    cyc(6);
    note(4'h0, ST_NORM);
    done("timers and polling");
    host.enter_lpm(24'h0, 24'h0);
    rst <= 1'h1;
    cyc(3);
    note(4'h0, ST_RESET);
    note(4'h8, 32'h1);
    note(4'h9, 32'h0);
    note(4'h3, 32'h0);
    rst <= 1'h0;
    cyc(1);
    note(4'h0, ST_UVLO);
    done("mid-run reset");
    cyc(2);
    complete_run();
  end
endmodule // switch_detector_power_mode_fsm_bench
